// *** rtl/timer16_pkg.sv ***
// ****************************************************************
// Shared constants for the 16-bit interval, pulse and capture timer
// ****************************************************************
package timer16_pkg;
	// Counter and register width
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	// Prescaler width and terminal counts for the two internal dividers
	localparam int PRE_W = 8;
	localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
	localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
	localparam logic [PRE_W-1:0] DIV4_LAST = 8'h03;
	localparam logic [PRE_W-1:0] DIV256_LAST = 8'hff;

	// Count clock source selection
	localparam logic [1:0] CLK_SYS = 2'h0;
	localparam logic [1:0] CLK_DIV4 = 2'h1;
	localparam logic [1:0] CLK_DIV256 = 2'h2;
	localparam logic [1:0] CLK_EDGE_A = 2'h3;

	// Valid edge selection codes; 2'h2 is prohibited and detects nothing
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Counter operating mode
	typedef enum logic [1:0] {
		MODE_STOP,
		MODE_CLEAR_ON_MATCH,
		MODE_FREE_RUN
	} timer_mode_t;

	// Capture arrangement used in free-running mode
	typedef enum logic [1:0] {
		CAP_SINGLE,
		CAP_DUAL,
		CAP_TWO_REG
	} capture_mode_t;
endpackage

// *** rtl/edge_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-sample noise filter and valid edge detector for one input
// ****************************************************************
module edge_filter
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Sampling strobe and pin
	input wire logic sample_in,
	input wire logic pin_in,
	input wire logic [1:0] edge_sel_in,
	// Filtered edge pulses, one cycle each
	output logic valid_edge_out,
	output logic rise_out,
	output logic fall_out
);
	import timer16_pkg::*;

	logic samp; // Previous sample
	logic level; // Accepted filtered level
	logic next_samp;
	logic next_level;
	logic next_rise;
	logic next_fall;
	logic next_valid;

	// Accept a new level only when two successive samples agree
	always_comb
	begin
		next_samp = samp;
		next_level = level;
		next_rise = 1'b0;
		next_fall = 1'b0;
		if (sample_in)
		begin
			next_samp = pin_in;
			if (samp == pin_in && pin_in != level) // Short pulses never get here
			begin
				next_level = pin_in;
				next_rise = pin_in;
				next_fall = ~pin_in;
			end
		end
		// Edge code decode; the prohibited code matches nothing
		case (edge_sel_in)
			EDGE_FALL: next_valid = next_fall;
			EDGE_RISE: next_valid = next_rise;
			EDGE_BOTH: next_valid = next_rise | next_fall;
			default: next_valid = 1'b0;
		endcase
	end

	// Level resets low, so a pin already high shows a rise once running
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			samp <= 1'b0;
			level <= 1'b0;
			rise_out <= 1'b0;
			fall_out <= 1'b0;
			valid_edge_out <= 1'b0;
		end
		else
		begin
			samp <= next_samp;
			level <= next_level;
			rise_out <= next_rise;
			fall_out <= next_fall;
			valid_edge_out <= next_valid;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_filter_two_samples: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(rise_out | fall_out) |-> ($past(sample_in) && $past(pin_in) == $past(samp)))
		else $error("edge accepted without two agreeing samples");
	a_edge_decode: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		valid_edge_out |-> ($past(edge_sel_in) != 2'h2))
		else $error("edge reported for prohibited edge code");
endmodule // edge_filter
`default_nettype wire

// *** rtl/timer16_capture.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Interval mode: clear and interrupt every N+1 counts.
// - Clear-on-match sets overflow only when compare is FFFFH.
// - Pulse mode drives waves; period A, width B.
// - Period A+1 counts; duty (A-B)/(A+1).
// - Clear-on-match modes reset counter and keep counting.
// - Capture only after two agreeing input samples.
// - Single capture: input A edge loads B, irq B.
// - Dual: input B edge loads A, irq A.
// - Two-register: selected edge loads B, opposite loads A.
// - Edge codes: 00 fall, 01 rise, 11 both.
// - Output pin held low unless output enabled.
// - Count source: clock, /4, /256, input A edges.
module timer16_capture
	import timer16_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Mode and clock configuration
	input wire timer16_pkg::timer_mode_t timer_mode_in,
	input wire timer16_pkg::capture_mode_t capture_mode_in,
	input wire logic [1:0] count_clock_sel_in,
	input wire logic [1:0] input_a_edge_sel_in,
	input wire logic [1:0] input_b_edge_sel_in,
	// Output control
	input wire logic invert_on_a_match_in,
	input wire logic invert_on_b_match_in,
	input wire logic output_enable_in,
	// Software writes and flag clear
	input wire logic compare_a_wr_in,
	input wire logic compare_b_wr_in,
	input wire logic [timer16_pkg::CNT_W-1:0] compare_wdata_in,
	input wire logic overflow_clr_in,
	// Capture pins
	input wire logic capture_input_a_in,
	input wire logic capture_input_b_in,
	// State and results
	output logic [timer16_pkg::CNT_W-1:0] timer_count_out,
	output logic [timer16_pkg::CNT_W-1:0] compare_capture_a_out,
	output logic [timer16_pkg::CNT_W-1:0] compare_capture_b_out,
	output logic overflow_flag_out,
	// Events and output pin
	output logic match_a_irq_out,
	output logic match_b_irq_out,
	output logic pulse_output_pin_out
);
	import timer16_pkg::*;

	// ****************************************************************
	// Count clock generation
	// ****************************************************************
	logic [PRE_W-1:0] prescale; // Divider of the system clock, held at zero while stopped
	logic [PRE_W-1:0] next_prescale;
	logic tick; // One count clock period has elapsed
	logic sample_a; // Sampling strobe for input A
	logic edge_a; // Filtered valid edge on input A
	logic rise_a; // Filtered rise on input A
	logic fall_a; // Filtered fall on input A
	logic edge_b; // Filtered valid edge on input B
	logic running; // Counter is not stopped

	assign running = (timer_mode_in != MODE_STOP);

	// Divider runs only while the counter runs, so it starts in phase
	always_comb
	begin
		next_prescale = running ? prescale + PRE_ONE : PRE_ZERO;
		case (count_clock_sel_in)
			CLK_SYS: tick = running;
			CLK_DIV4: tick = running && (prescale[1:0] == DIV4_LAST[1:0]);
			CLK_DIV256: tick = running && (prescale == DIV256_LAST);
			CLK_EDGE_A: tick = running && edge_a;
			default: tick = 1'b0;
		endcase
		// External counting samples every clock; otherwise the count clock samples
		sample_a = (count_clock_sel_in == CLK_EDGE_A) ? 1'b1 : tick;
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			prescale <= PRE_ZERO;
		else
			prescale <= next_prescale;
	end

	// Input A filter, sampled with the count clock, or every clock when counting input A edges
	edge_filter filt_a (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.sample_in(sample_a),
		.pin_in(capture_input_a_in),
		.edge_sel_in(input_a_edge_sel_in),
		.valid_edge_out(edge_a),
		.rise_out(rise_a),
		.fall_out(fall_a)
	);

	// Input B filter, sampled with the count clock
	edge_filter filt_b (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.sample_in(tick),
		.pin_in(capture_input_b_in),
		.edge_sel_in(input_b_edge_sel_in),
		.valid_edge_out(edge_b),
		.rise_out(),
		.fall_out()
	);

	// ****************************************************************
	// Counter, compare, capture and output
	// ****************************************************************
	logic clear_mode; // Interval or pulse generation mode
	logic free_mode; // Free-running capture mode
	logic match_a; // Count equals compare A on a tick
	logic match_b; // Count equals compare B on a tick
	logic opp_a; // Edge opposite to the selected one on input A
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] next_cc_a;
	logic [CNT_W-1:0] next_cc_b;
	logic next_ovf;
	logic next_irq_a;
	logic next_irq_b;
	logic next_out_ff;
	logic out_ff; // Waveform before the output gate

	always_comb
	begin
		clear_mode = (timer_mode_in == MODE_CLEAR_ON_MATCH);
		free_mode = (timer_mode_in == MODE_FREE_RUN);
		match_a = clear_mode && tick && (timer_count_out == compare_capture_a_out);
		match_b = clear_mode && tick && (timer_count_out == compare_capture_b_out);
		case (input_a_edge_sel_in) // Opposite edge is only defined for a single edge
			EDGE_RISE: opp_a = fall_a;
			EDGE_FALL: opp_a = rise_a;
			default: opp_a = 1'b0;
		endcase
		next_count = timer_count_out;
		next_ovf = overflow_flag_out & ~overflow_clr_in; // Set below wins over clear
		next_irq_a = 1'b0;
		next_irq_b = 1'b0;
		next_cc_a = compare_a_wr_in ? compare_wdata_in : compare_capture_a_out;
		next_cc_b = compare_b_wr_in ? compare_wdata_in : compare_capture_b_out;
		next_out_ff = out_ff;
		if (!running)
		begin
			next_count = CNT_ZERO; // Stopped counter sits at zero
			next_out_ff = 1'b0;
		end
		else if (match_a)
		begin
			next_count = CNT_ZERO;
			next_irq_a = 1'b1;
			if (compare_capture_a_out == CNT_MAX)
				next_ovf = 1'b1;
		end
		else if (tick)
		begin
			next_count = timer_count_out + CNT_ONE;
			if (free_mode && timer_count_out == CNT_MAX)
				next_ovf = 1'b1; // Sum drops the carry, so it wraps to zero
		end
		// Output inversion on enabled matches, A then B in one tick cancels
		if (match_a && invert_on_a_match_in)
			next_out_ff = ~next_out_ff;
		if (match_b && invert_on_b_match_in)
			next_out_ff = ~next_out_ff;
		if (match_b)
			next_irq_b = 1'b1;
		// Captures take priority over a software write in the same cycle
		if (free_mode && edge_a)
		begin
			next_cc_b = timer_count_out;
			next_irq_b = 1'b1;
		end
		if (free_mode && capture_mode_in == CAP_DUAL && edge_b)
		begin
			next_cc_a = timer_count_out;
			next_irq_a = 1'b1;
		end
		if (free_mode && capture_mode_in == CAP_TWO_REG && opp_a)
			next_cc_a = timer_count_out;
	end

	// Registered results and pin; pin gated low while output is disabled
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			timer_count_out <= CNT_ZERO;
			compare_capture_a_out <= CNT_ZERO;
			compare_capture_b_out <= CNT_ZERO;
			overflow_flag_out <= 1'b0;
			match_a_irq_out <= 1'b0;
			match_b_irq_out <= 1'b0;
			out_ff <= 1'b0;
			pulse_output_pin_out <= 1'b0;
		end
		else
		begin
			timer_count_out <= next_count;
			compare_capture_a_out <= next_cc_a;
			compare_capture_b_out <= next_cc_b;
			overflow_flag_out <= next_ovf;
			match_a_irq_out <= next_irq_a;
			match_b_irq_out <= next_irq_b;
			out_ff <= next_out_ff;
			pulse_output_pin_out <= output_enable_in & next_out_ff;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_interval_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		match_a |=> (timer_count_out == CNT_ZERO) && match_a_irq_out)
		else $error("counter not cleared on compare A match");
	a_irq_period: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(match_a_irq_out && clear_mode && count_clock_sel_in == CLK_SYS
			&& compare_capture_a_out == 16'h0003 && !compare_a_wr_in)
		##1 (clear_mode && count_clock_sel_in == CLK_SYS && !compare_a_wr_in)[*4]
		|-> match_a_irq_out)
		else $error("interval interrupt not every N+1 counts");
	a_ovf_only_ffff: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(match_a && compare_capture_a_out != CNT_MAX && !overflow_flag_out) |=> !overflow_flag_out)
		else $error("overflow set on compare below FFFFH");
	a_wrap_ovf: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(free_mode && tick && timer_count_out == CNT_MAX) |=> overflow_flag_out && timer_count_out == CNT_ZERO)
		else $error("free-run wrap missed overflow");
	a_pin_gated: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!output_enable_in |=> !pulse_output_pin_out)
		else $error("output pin driven while disabled");
	a_ppg_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(match_b && invert_on_b_match_in && !match_a && output_enable_in) ##1 output_enable_in
		|-> pulse_output_pin_out != $past(pulse_output_pin_out))
		else $error("output not inverted on compare B match");
	a_single_capture: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(free_mode && edge_a) |=> compare_capture_b_out == $past(timer_count_out) && match_b_irq_out)
		else $error("input A edge did not capture into B");
	a_dual_capture: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(free_mode && capture_mode_in == CAP_DUAL && edge_b)
		|=> compare_capture_a_out == $past(timer_count_out) && match_a_irq_out)
		else $error("input B edge did not capture into A");
	a_opposite_capture: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(free_mode && capture_mode_in == CAP_TWO_REG && opp_a) |=> compare_capture_a_out == $past(timer_count_out))
		else $error("opposite edge did not capture into A");

	c_interval: cover property (@(posedge clk_in) match_a_irq_out ##[1:20] match_a_irq_out);
	c_ppg_high: cover property (@(posedge clk_in) clear_mode && output_enable_in && pulse_output_pin_out);
	c_capture: cover property (@(posedge clk_in) free_mode && edge_a ##[1:50] edge_a);
	c_wrap: cover property (@(posedge clk_in) free_mode && overflow_flag_out);
endmodule // timer16_capture
`default_nettype wire

// *** tb/pulse_source.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Signal source standing on the two capture pins
// ****************************************************************
module pulse_source
(
	// Clock
	input wire logic clk_in,
	// Commanded levels and a one-cycle spike on pin A
	input wire logic lvl_a_in,
	input wire logic lvl_b_in,
	input wire logic spike_in,
	// Pin levels seen by the timer
	output var logic pin_a_out = 1'b0,
	output var logic pin_b_out = 1'b0
);
	// Registered, so the pins move just after an edge and never race it
	always @(posedge clk_in)
	begin
		pin_a_out <= lvl_a_in ^ spike_in;
		pin_b_out <= lvl_b_in;
	end
endmodule // pulse_source
`default_nettype wire

// *** tb/timer16_interval_ppg_capture_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer16_interval_ppg_capture_tb;
	import timer16_pkg::*;
	// ****************************************************************
	// Stimulus and observed signals
	// ****************************************************************
	logic clk_in = 0, sys_rst_in = 1;
	timer_mode_t mode = MODE_STOP;
	capture_mode_t cmode = CAP_SINGLE;
	logic [1:0] csel = 0, ea = 0, eb = 0;
	logic inv_a = 0, inv_b = 0, oe = 0, wa = 0, wb = 0, oclr = 0, la = 0, lb = 0, spk = 0;
	logic [15:0] wd = 0, cnt, cca, ccb, a0, a1, b0, b1;
	logic ovf, ia, ib, pin, pa, pb;
	int err_count = 0, n_tests = 0, n_a = 0, n_b = 0, cyc = 0, prev_a = 0, last_a = 0;
	int a, b, w, d, h, k;
	logic [1:0] ec [4] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH, 2'h2};
	int ex [4] = '{1, 1, 2, 0};
	pulse_source src (.clk_in(clk_in), .lvl_a_in(la), .lvl_b_in(lb), .spike_in(spk), .pin_a_out(pa), .pin_b_out(pb));
	timer16_capture dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .timer_mode_in(mode), .capture_mode_in(cmode),
		.count_clock_sel_in(csel), .input_a_edge_sel_in(ea), .input_b_edge_sel_in(eb),
		.invert_on_a_match_in(inv_a), .invert_on_b_match_in(inv_b), .output_enable_in(oe),
		.compare_a_wr_in(wa), .compare_b_wr_in(wb), .compare_wdata_in(wd), .overflow_clr_in(oclr),
		.capture_input_a_in(pa), .capture_input_b_in(pb), .timer_count_out(cnt),
		.compare_capture_a_out(cca), .compare_capture_b_out(ccb), .overflow_flag_out(ovf),
		.match_a_irq_out(ia), .match_b_irq_out(ib), .pulse_output_pin_out(pin));
	// 40 MHz system clock
	initial
	begin
		forever #12.5 clk_in = ~clk_in;
	end
	// Monitor: irq counts, interval timing and capture history
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (ia === 1'b1)
		begin
			n_a <= n_a + 1;
			prev_a <= last_a;
			last_a <= cyc;
			a1 <= a0;
			a0 <= cca;
		end
		if (ib === 1'b1)
		begin
			n_b <= n_b + 1;
			b1 <= b0;
			b0 <= ccb;
		end
	end
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	// Expected interrupt spacing in system clocks for compare n and divider div
	function automatic logic [15:0] exp_period(input int n, input int div);
		return 16'((n + 1) * div);
	endfunction
	// High cycles per period: period n+1 less the m+1 low phase
	function automatic logic [15:0] exp_high(input int n, input int m);
		return 16'((n + 1) - (m + 1));
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One-cycle write strobe into compare A or B
	task automatic wr(input logic to_b, input logic [15:0] v);
		@(posedge clk_in);
		wa <= !to_b;
		wb <= to_b;
		wd <= v;
		@(posedge clk_in);
		wa <= 0;
		wb <= 0;
	endtask
	// Configure first, start the counter last
	task automatic run(input timer_mode_t m, input capture_mode_t c, input logic [1:0] s, e_a, e_b);
		@(posedge clk_in);
		cmode <= c;
		csel <= s;
		ea <= e_a;
		eb <= e_b;
		@(posedge clk_in);
		mode <= m;
	endtask
	task automatic stop();
		@(posedge clk_in);
		mode <= MODE_STOP;
		tick(3);
		chk("stopped count", 0, cnt);
	endtask
	// Pulse of n system clocks on pin A or pin B
	task automatic pulse(input logic on_b, input int n);
		@(posedge clk_in);
		{lb, la} <= on_b ? 2'b10 : 2'b01;
		tick(n);
		{lb, la} <= 2'b00;
		tick(30);
	endtask
	// High cycles of the output pin over n cycles
	task automatic measure(input int n);
		h = 0;
		repeat (n)
		begin
			@(posedge clk_in);
			h += (pin === 1'b1);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog at 90k cycles, well above the ~73k cycles the sequence needs
	initial
	begin
		#2250000;
		err_count++;
		report_and_stop();
	end
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(51));
		tick(6);
		chk("reset count", 0, cnt);
		chk("reset flags", 0, {ovf, ia, ib, pin});
		sys_rst_in <= 0;
		// Interval period on each internal count source
		for (int s = 0; s < 3; s++)
		begin
			a = (s == 0) ? 3 : 1 + $urandom % 7; // Corner: compare 3 on the system clock
			d = (s == 0) ? 1 : ((s == 1) ? 4 : 256);
			wr(0, 16'(a));
			run(MODE_CLEAR_ON_MATCH, CAP_SINGLE, 2'(s), EDGE_FALL, EDGE_FALL);
			tick(3 * (a + 1) * d + 10);
			chk("interval", exp_period(a, d), 16'(last_a - prev_a));
			chk("overflow small", 0, ovf);
			stop();
		end
		// External edges as count clock: three rises reach compare 2
		wr(0, 16'h0002);
		run(MODE_CLEAR_ON_MATCH, CAP_SINGLE, CLK_EDGE_A, EDGE_RISE, EDGE_FALL);
		k = n_a;
		repeat (3) pulse(0, 4);
		chk("edge count", 1, 16'(n_a - k));
		stop();
		// Full free-running pass: wrap past FFFFH sets overflow
		run(MODE_FREE_RUN, CAP_SINGLE, CLK_SYS, EDGE_FALL, EDGE_FALL);
		tick(65545);
		chk("overflow wrap", 1, ovf);
		@(posedge clk_in);
		oclr <= 1;
		@(posedge clk_in);
		oclr <= 0;
		tick(2);
		chk("overflow clear", 0, ovf);
		stop();
		$display("interval tests done");
		// Pulse generator; B kept at 6 or more so the width change dodges B matches
		a = 10 + $urandom % 6;
		b = 6 + $urandom % (a - 6);
		wr(0, 16'(a));
		wr(1, 16'(b));
		inv_a <= 1;
		inv_b <= 1;
		oe <= 1;
		run(MODE_CLEAR_ON_MATCH, CAP_SINGLE, CLK_SYS, EDGE_FALL, EDGE_FALL);
		tick(3 * (a + 1));
		measure(a + 1);
		chk("pulse high", exp_high(a, b), 16'(h));
		b = 6 + $urandom % (a - 6);
		k = 0;
		while (ia !== 1'b1 && k < 100)
		begin
			@(posedge clk_in);
			k++;
		end
		inv_b <= 0;
		wr(1, 16'(b));
		tick(1);
		inv_b <= 1;
		tick(2 * (a + 1));
		measure(a + 1);
		chk("new width", exp_high(a, b), 16'(h));
		oe <= 0;
		tick(2);
		measure(a + 1);
		chk("output off", 0, 16'(h));
		stop();
		$display("pulse tests done");
		// Single capture over every edge code, including the prohibited one
		for (int i = 0; i < 4; i++)
		begin
			run(MODE_FREE_RUN, CAP_SINGLE, CLK_SYS, ec[i], EDGE_FALL);
			tick(4);
			k = n_b;
			w = 5 + $urandom % 40;
			pulse(0, w);
			chk("capture count", 16'(ex[i]), 16'(n_b - k));
			if (i == 2)
			begin
				chk("single width", 16'(w), b0 - b1);
				k = n_b;
				@(posedge clk_in);
				spk <= 1;
				@(posedge clk_in);
				spk <= 0;
				tick(10);
				chk("spike ignored", 16'(k), 16'(n_b));
			end
			stop();
		end
		// Dual pulse widths: pin B loads compare A
		run(MODE_FREE_RUN, CAP_DUAL, CLK_SYS, EDGE_BOTH, EDGE_BOTH);
		tick(4);
		k = n_a;
		pulse(1, w);
		chk("dual count", 2, 16'(n_a - k));
		chk("dual width", 16'(w), a0 - a1);
		stop();
		// Two registers: rise into B, fall into A
		run(MODE_FREE_RUN, CAP_TWO_REG, CLK_SYS, EDGE_RISE, EDGE_FALL);
		tick(4);
		pulse(0, w);
		chk("two reg width", 16'(w), cca - ccb);
		stop();
		$display("capture tests done");
		report_and_stop();
	end
endmodule // timer16_interval_ppg_capture_tb
`default_nettype wire
